// [rtl/timer_pkg.sv]
/*
  constants shared by the timer: register offsets, field positions,
  reset values and clock source codes.
  assumes a byte-wide register view placed in the low bits of a 32-bit apb word.
*/
package timer_pkg;
  // bus and datapath widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 16;
  localparam int PSC_W = 7;
  localparam int PS_W = 3;
  // register byte addresses
  localparam logic [7:0] OFS_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COUNTER_HIGH = 8'h04;
  localparam logic [7:0] OFS_COUNTER_LOW = 8'h08;
  localparam logic [7:0] OFS_MODULUS_HIGH = 8'h0c;
  localparam logic [7:0] OFS_MODULUS_LOW = 8'h10;
  // channel n occupies block CH_FIRST_BLOCK + n, sixteen bytes each
  localparam logic [3:0] CH_FIRST_BLOCK = 4'h2;
  localparam logic [3:0] SUB_CHANNEL_CONTROL = 4'h0;
  localparam logic [3:0] SUB_VALUE_HIGH = 4'h4;
  localparam logic [3:0] SUB_VALUE_LOW = 4'h8;
  // timer_control fields
  localparam int TC_OVF = 7;
  localparam int TC_OVF_IE = 6;
  localparam int TC_CENTER = 5;
  localparam int TC_CLK_HI = 4;
  localparam int TC_CLK_LO = 3;
  localparam int TC_PS_HI = 2;
  localparam logic [7:0] TC_WMASK = 8'h7f;
  // channel_control fields
  localparam int CC_FLAG = 7;
  localparam int CC_IE = 6;
  localparam int CC_MB = 5;
  localparam int CC_MA = 4;
  localparam int CC_EB = 3;
  localparam int CC_EA = 2;
  localparam logic [7:0] CC_WMASK = 8'h7c;
  // reset values
  localparam logic [7:0] TC_RESET = 8'h00;
  localparam logic [7:0] CC_RESET = 8'h00;
  // counter values
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_FREE_TOP = 16'hffff;
  localparam logic [7:0] PSC_ONE = 8'h01;
  // clock source codes
  localparam logic [1:0] CLK_OFF = 2'h0;
  localparam logic [1:0] CLK_BUS = 2'h1;
  localparam logic [1:0] CLK_FIXED = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
endpackage : timer_pkg

// [rtl/timer_capture_compare_pwm.sv]
/*
  16-bit timer with modulus, prescaler and per-channel capture, compare
  and pwm, reached over an apb slave with byte-wide registers.
  assumes fixed_tick and debug_halt come from logic on pclk; pins are async.
*/
// Local design decisions: the APB slave port and the placing of the registers.
// What this block does
// - center select gives up/down, else wrapping up-count
// - terminal count is modulus, or all ones
// - up/down endpoints each last one tick
// - center mode overflow on turn downward
// - counter write clears count and read latch
// - mode bits choose capture, compare or pwm
// - capture copies counter on selected edge
// - capture mode value bytes ignore writes
// - capture-mode value byte read latches partner byte
// - capture sets channel event flag
// - capture keeps working during debug halt
// - compare match sets, clears or toggles pin
// - compare value applies after both bytes; in debug halt each byte write goes straight in
// - compare match sets channel event flag
// - edge pwm high at overflow, low at match
// - edge pwm zero gives 0%, above modulus 100%
// - pwm value applies at modulus-minus-one step
// - center pwm low on up match, high down
// - center pwm zero/negative 0%, above modulus 100%
// - control writes cancel pending byte buffers
// - clock field selects off, bus, fixed, external
// - up-count overflow flag on wrap to zero
module timer_capture_compare_pwm #(
  parameter int NUM_CH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [timer_pkg::DATA_W-1:0] pwdata,
  output logic [timer_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic debug_halt,
  input wire logic fixed_tick,
  input wire logic ext_clk_pin,
  input wire logic [NUM_CH-1:0] ch_in,
  output logic [NUM_CH-1:0] ch_out,
  output logic [NUM_CH-1:0] ch_oe,
  output logic overflow_flag,
  output logic [NUM_CH-1:0] channel_event_flag
);
  localparam int BW = timer_pkg::BYTE_W;
  localparam int CW = timer_pkg::CNT_W;

  // bus registers
  logic pready_q;
  logic pslverr_q;
  logic [timer_pkg::DATA_W-1:0] prdata_q;
  // timer state
  logic [7:0] tc_q; // control bits, overflow flag kept apart
  logic ovf_q; // overflow flag
  logic ovf_arm_q; // flag read while set
  logic [CW-1:0] cnt_q; // main counter
  logic dir_up_q; // up/down direction
  logic [timer_pkg::PSC_W-1:0] psc_q; // prescaler count
  logic [CW-1:0] mod_q; // active modulus
  logic [BW-1:0] mod_bh_q; // modulus byte buffers
  logic [BW-1:0] mod_bl_q;
  logic mod_wh_q; // byte written flags
  logic mod_wl_q;
  logic mod_pend_q; // both bytes in, waiting for update point
  logic cnt_lat_q; // counter read latch valid
  logic cnt_first_hi_q; // high byte was read first
  logic [BW-1:0] cnt_buf_q; // partner byte of counter
  // external clock synchroniser
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;

  // apb strobes: effects land on the edge that raises pready
  wire acc = psel & penable & ~pready_q;
  wire wr_acc = acc & pwrite;
  wire rd_acc = acc & ~pwrite;
  wire [BW-1:0] wbyte = pwdata[BW-1:0];
  wire sel_tc = paddr == timer_pkg::OFS_TIMER_CONTROL;
  wire sel_ch_hi = paddr == timer_pkg::OFS_COUNTER_HIGH;
  wire sel_ch_lo = paddr == timer_pkg::OFS_COUNTER_LOW;
  wire sel_mh = paddr == timer_pkg::OFS_MODULUS_HIGH;
  wire sel_ml = paddr == timer_pkg::OFS_MODULUS_LOW;
  wire w_tc = wr_acc & sel_tc;
  wire w_cnt = wr_acc & (sel_ch_hi | sel_ch_lo);
  wire w_mh = wr_acc & sel_mh;
  wire w_ml = wr_acc & sel_ml;
  wire r_tc = rd_acc & sel_tc;
  wire r_cnt = rd_acc & (sel_ch_hi | sel_ch_lo);

  // clock source and prescaler
  wire [1:0] clk_src = tc_q[timer_pkg::TC_CLK_HI:timer_pkg::TC_CLK_LO];
  wire center = tc_q[timer_pkg::TC_CENTER];
  wire clk_off = clk_src == timer_pkg::CLK_OFF;
  wire ext_rise = ext_s2_q & ~ext_s3_q;
  wire src_pulse = (clk_src == timer_pkg::CLK_BUS) | ((clk_src == timer_pkg::CLK_FIXED) & fixed_tick)
    | ((clk_src == timer_pkg::CLK_EXT) & ext_rise);
  wire [7:0] psc_mask8 = (timer_pkg::PSC_ONE << tc_q[timer_pkg::TC_PS_HI:0]) - timer_pkg::PSC_ONE;
  wire [timer_pkg::PSC_W-1:0] psc_mask = psc_mask8[timer_pkg::PSC_W-1:0];
  wire src_run = src_pulse & ~debug_halt; // debug halt freezes the count
  wire tick = src_run & ((psc_q & psc_mask) == psc_mask);

  wire [CW-1:0] term = (mod_q == timer_pkg::CNT_ZERO) ? timer_pkg::CNT_FREE_TOP : mod_q;
  // pwm update point, one below terminal count
  wire upd_point = tick & (cnt_q == term - timer_pkg::CNT_ONE);

  // next count, direction and end-of-count events
  logic [CW-1:0] cnt_d;
  logic dir_d;
  logic wrap;
  logic turn;
  logic step_up;
  always_comb
  begin
    cnt_d = cnt_q;
    dir_d = dir_up_q;
    wrap = 1'b0;
    turn = 1'b0;
    step_up = 1'b1;
    if (center)
    begin
      // turn at modulus and at zero, one tick each
      if (dir_up_q && cnt_q == mod_q)
      begin
        cnt_d = cnt_q - timer_pkg::CNT_ONE;
        dir_d = 1'b0;
        turn = 1'b1;
        step_up = 1'b0;
      end
      else if (dir_up_q || cnt_q == timer_pkg::CNT_ZERO)
      begin
        cnt_d = cnt_q + timer_pkg::CNT_ONE;
        dir_d = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q - timer_pkg::CNT_ONE;
        step_up = 1'b0;
      end
    end
    else if (cnt_q == term)
    begin
      // wrap from terminal count
      cnt_d = timer_pkg::CNT_ZERO;
      wrap = 1'b1;
    end
    else
    begin
      cnt_d = cnt_q + timer_pkg::CNT_ONE;
    end
  end

  wire ovf_ev = tick & (wrap | turn);
  wire tick_wrap = tick & wrap;

  // counter read coherency: returned byte
  wire cnt_use_buf_hi = cnt_lat_q & ~cnt_first_hi_q & ~debug_halt;
  wire cnt_use_buf_lo = cnt_lat_q & cnt_first_hi_q & ~debug_halt;
  wire [BW-1:0] cnt_rd_hi = cnt_use_buf_hi ? cnt_buf_q : cnt_q[CW-1:BW];
  wire [BW-1:0] cnt_rd_lo = cnt_use_buf_lo ? cnt_buf_q : cnt_q[BW-1:0];

  // modulus buffer completion and transfer
  wire mod_both = (mod_wh_q | w_mh) & (mod_wl_q | w_ml) & (w_mh | w_ml);
  wire [BW-1:0] mod_nh = w_mh ? wbyte : mod_bh_q;
  wire [BW-1:0] mod_nl = w_ml ? wbyte : mod_bl_q;

  // external clock pin synchroniser and edge stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end
    else
    begin
      ext_s1_q <= ext_clk_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // counter and prescaler
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= timer_pkg::CNT_ZERO;
      dir_up_q <= 1'b1;
      psc_q <= '0;
    end
    else if (w_cnt)
    begin
      cnt_q <= timer_pkg::CNT_ZERO;
      dir_up_q <= 1'b1;
      psc_q <= '0;
    end
    else
    begin
      if (tick)
      begin
        cnt_q <= cnt_d;
        dir_up_q <= dir_d;
      end
      if (src_run)
      begin
        psc_q <= tick ? '0 : psc_q + 1'b1;
      end
    end
  end

  // counter read latch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_lat_q <= 1'b0;
      cnt_first_hi_q <= 1'b0;
      cnt_buf_q <= '0;
    end
    else if (w_cnt || w_tc)
    begin
      cnt_lat_q <= 1'b0;
    end
    else if (r_cnt && !debug_halt)
    begin
      // second half of a pair releases, otherwise latch partner
      if (cnt_lat_q && (cnt_first_hi_q != sel_ch_hi))
      begin
        cnt_lat_q <= 1'b0;
      end
      else
      begin
        cnt_lat_q <= 1'b1;
        cnt_first_hi_q <= sel_ch_hi;
        cnt_buf_q <= sel_ch_hi ? cnt_q[BW-1:0] : cnt_q[CW-1:BW];
      end
    end
  end

  // timer control and overflow flag, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tc_q <= timer_pkg::TC_RESET;
      ovf_q <= 1'b0;
      ovf_arm_q <= 1'b0;
    end
    else
    begin
      if (w_tc)
      begin
        tc_q <= wbyte & timer_pkg::TC_WMASK;
      end
      if (ovf_ev)
      begin
        ovf_q <= 1'b1;
        ovf_arm_q <= 1'b0;
      end
      else if (w_tc && !wbyte[timer_pkg::TC_OVF] && ovf_arm_q)
      begin
        ovf_q <= 1'b0;
        ovf_arm_q <= 1'b0;
      end
      else if (r_tc && ovf_q)
      begin
        ovf_arm_q <= 1'b1;
      end
    end
  end

  // modulus buffering
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mod_q <= timer_pkg::CNT_ZERO;
      mod_bh_q <= '0;
      mod_bl_q <= '0;
      mod_wh_q <= 1'b0;
      mod_wl_q <= 1'b0;
      mod_pend_q <= 1'b0;
    end
    else if (w_tc)
    begin
      mod_wh_q <= 1'b0;
      mod_wl_q <= 1'b0;
      mod_pend_q <= 1'b0;
    end
    else
    begin
      mod_bh_q <= mod_nh;
      mod_bl_q <= mod_nl;
      if (mod_both)
      begin
        mod_wh_q <= 1'b0;
        mod_wl_q <= 1'b0;
        // immediate when stopped, else at update point
        if (clk_off)
        begin
          mod_q <= {mod_nh, mod_nl};
        end
        else
        begin
          mod_pend_q <= 1'b1;
        end
      end
      else
      begin
        mod_wh_q <= mod_wh_q | w_mh;
        mod_wl_q <= mod_wl_q | w_ml;
        if (mod_pend_q && (upd_point || clk_off))
        begin
          mod_q <= {mod_bh_q, mod_bl_q};
          mod_pend_q <= 1'b0;
        end
      end
    end
  end

  // per-channel logic
  logic [NUM_CH-1:0] ch_hit;
  logic [BW-1:0] ch_rd [NUM_CH];
  genvar n;
  generate
    for (n = 0; n < NUM_CH; n++)
    begin : g_ch
      localparam logic [3:0] BLK = 4'(timer_pkg::CH_FIRST_BLOCK + 4'(n));
      logic [7:0] ctl_q; // channel control bits
      logic flag_q; // channel event flag
      logic arm_q; // flag read while set
      logic [CW-1:0] cv_q; // active channel value
      logic [BW-1:0] bh_q; // value byte buffers
      logic [BW-1:0] bl_q;
      logic wh_q;
      logic wl_q;
      logic pend_q;
      logic lat_q; // read latch valid
      logic first_hi_q;
      logic [BW-1:0] rbuf_q;
      logic out_q;
      logic oe_q;
      logic s1_q;
      logic s2_q;
      logic s3_q;
      wire blk = paddr[7:4] == BLK;
      wire s_cc = blk & (paddr[3:0] == timer_pkg::SUB_CHANNEL_CONTROL);
      wire s_vh = blk & (paddr[3:0] == timer_pkg::SUB_VALUE_HIGH);
      wire s_vl = blk & (paddr[3:0] == timer_pkg::SUB_VALUE_LOW);
      wire w_cc = wr_acc & s_cc;
      wire r_cc = rd_acc & s_cc;
      wire eb = ctl_q[timer_pkg::CC_EB];
      wire ea = ctl_q[timer_pkg::CC_EA];
      wire m_cap = ~center & ~ctl_q[timer_pkg::CC_MB] & ~ctl_q[timer_pkg::CC_MA];
      wire m_oc = ~center & ~ctl_q[timer_pkg::CC_MB] & ctl_q[timer_pkg::CC_MA];
      wire m_ep = ~center & ctl_q[timer_pkg::CC_MB];
      wire m_pwm = m_ep | center;
      wire w_vh = wr_acc & s_vh & ~m_cap;
      wire w_vl = wr_acc & s_vl & ~m_cap;
      wire w_buf = (w_vh | w_vl) & ~debug_halt;
      wire both = (wh_q | w_vh) & (wl_q | w_vl) & w_buf;
      wire [BW-1:0] nh = w_vh ? wbyte : bh_q;
      wire [BW-1:0] nl = w_vl ? wbyte : bl_q;
      // compare applies next tick, pwm at update point
      wire apply = pend_q & (clk_off | (m_oc & tick) | (m_pwm & upd_point));
      wire rise = s2_q & ~s3_q;
      wire fall = ~s2_q & s3_q;
      wire cap_ev = m_cap & ((ea & rise) | (eb & fall));
      wire match = tick & ~m_cap & (cnt_d == cv_q);
      // value read coherency in capture mode
      wire coh = m_cap & ~debug_halt;
      wire use_buf = coh & lat_q & (first_hi_q != s_vh);
      wire [BW-1:0] rd_h = use_buf ? rbuf_q : cv_q[CW-1:BW];
      wire [BW-1:0] rd_l = use_buf ? rbuf_q : cv_q[BW-1:0];
      wire r_v = rd_acc & (s_vh | s_vl) & coh;
      wire cp_zero = (cv_q == timer_pkg::CNT_ZERO) | cv_q[CW-1];
      wire cp_full = cv_q > mod_q;
      assign ch_hit[n] = s_cc | s_vh | s_vl;
      assign ch_rd[n] = s_cc ? {flag_q, ctl_q[6:0]} : (s_vh ? rd_h : (s_vl ? rd_l : '0));

      // pin synchroniser plus edge stage
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end
        else
        begin
          s1_q <= ch_in[n];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end

      // control bits and event flag, set wins over clear
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          ctl_q <= timer_pkg::CC_RESET;
          flag_q <= 1'b0;
          arm_q <= 1'b0;
        end
        else
        begin
          if (w_cc)
          begin
            ctl_q <= wbyte & timer_pkg::CC_WMASK;
          end
          if (cap_ev || match)
          begin
            flag_q <= 1'b1;
            arm_q <= 1'b0;
          end
          else if (w_cc && !wbyte[timer_pkg::CC_FLAG] && arm_q)
          begin
            flag_q <= 1'b0;
            arm_q <= 1'b0;
          end
          else if (r_cc && flag_q)
          begin
            arm_q <= 1'b1;
          end
        end
      end

      // channel value, write buffers and read latch
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          cv_q <= timer_pkg::CNT_ZERO;
          bh_q <= '0;
          bl_q <= '0;
          wh_q <= 1'b0;
          wl_q <= 1'b0;
          pend_q <= 1'b0;
          lat_q <= 1'b0;
          first_hi_q <= 1'b0;
          rbuf_q <= '0;
        end
        else
        begin
          // capture holds the frozen count in debug
          if (cap_ev)
          begin
            cv_q <= cnt_q;
          end
          else if (debug_halt && w_vh)
          begin
            cv_q[CW-1:BW] <= wbyte;
          end
          else if (debug_halt && w_vl)
          begin
            cv_q[BW-1:0] <= wbyte;
          end
          else if (both && clk_off)
          begin
            cv_q <= {nh, nl};
          end
          else if (apply)
          begin
            cv_q <= {bh_q, bl_q};
          end
          if (w_cc)
          begin
            wh_q <= 1'b0;
            wl_q <= 1'b0;
            pend_q <= 1'b0;
            lat_q <= 1'b0;
          end
          else
          begin
            if (w_buf)
            begin
              bh_q <= nh;
              bl_q <= nl;
            end
            wh_q <= both ? 1'b0 : (wh_q | (w_vh & ~debug_halt));
            wl_q <= both ? 1'b0 : (wl_q | (w_vl & ~debug_halt));
            pend_q <= both ? ~clk_off : (pend_q & ~apply);
            if (r_v)
            begin
              lat_q <= ~use_buf;
              first_hi_q <= use_buf ? first_hi_q : s_vh;
              rbuf_q <= s_vh ? cv_q[BW-1:0] : cv_q[CW-1:BW];
            end
          end
        end
      end

      // pin drive per mode
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          out_q <= 1'b0;
          oe_q <= 1'b0;
        end
        else
        begin
          oe_q <= ~m_cap & (eb | ea);
          if (m_oc && match)
          begin
            case ({eb, ea})
              2'b01: out_q <= ~out_q;
              2'b10: out_q <= 1'b0;
              2'b11: out_q <= 1'b1;
              default: out_q <= out_q;
            endcase
          end
          else if (m_ep && match)
          begin
            // match beats wrap, zero value stays inactive
            out_q <= ea;
          end
          else if (m_ep && tick_wrap)
          begin
            out_q <= ~ea;
          end
          else if (center && cp_zero)
          begin
            out_q <= ea;
          end
          else if (center && cp_full)
          begin
            out_q <= ~ea;
          end
          else if (center && match)
          begin
            // up match ends, down match starts
            out_q <= step_up ? ea : ~ea;
          end
        end
      end
      assign ch_out[n] = out_q;
      assign ch_oe[n] = oe_q;
      assign channel_event_flag[n] = flag_q;
    end
  endgenerate

  // read data selection
  logic [BW-1:0] ch_rd_or;
  always_comb
  begin
    ch_rd_or = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      ch_rd_or = ch_rd_or | ch_rd[i];
    end
  end
  wire mapped = sel_tc | sel_ch_hi | sel_ch_lo | sel_mh | sel_ml | (|ch_hit);
  wire [BW-1:0] rd_byte = sel_tc ? {ovf_q, tc_q[6:0]}
    : sel_ch_hi ? cnt_rd_hi
    : sel_ch_lo ? cnt_rd_lo
    : sel_mh ? mod_q[CW-1:BW]
    : sel_ml ? mod_q[BW-1:0]
    : ch_rd_or;

  // apb answer: pready one cycle after the access phase opens
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= acc;
      pslverr_q <= acc & ~mapped;
      if (rd_acc)
      begin
        prdata_q <= {{(timer_pkg::DATA_W-BW){1'b0}}, rd_byte};
      end
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign overflow_flag = ovf_q;
endmodule : timer_capture_compare_pwm

// [tb/pin_partner.sv]
/* far-side pin model: drives the capture pins and the external clock pin.
   assumes the bench changes pin requests by non-blocking assignment at clock edges. */
module pin_partner (
  input wire logic pclk,
  input wire logic [1:0] pin_req,
  output logic [1:0] ch_in,
  output logic ext_clk_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins follow the request one edge late, as a slow source would
  always @(posedge pclk)
  begin
    ch_in <= pin_req;
  end
  // free-running external source at a quarter of pclk, the fastest allowed
  logic [1:0] div = 2'h0;
  always @(posedge pclk)
  begin
    div <= div + 2'h1;
  end
  assign ext_clk_pin = div[1];
endmodule : pin_partner

// [tb/timer_capture_compare_pwm_properties.sv]
/* checker for the timer apb answer and the sticky flags.
   assumes it is bound to the timer top module. */
module timer_checker #(
  parameter int NUM_CH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [timer_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_CH-1:0] ch_oe,
  input wire logic overflow_flag,
  input wire logic [NUM_CH-1:0] channel_event_flag
);
  // write strobes of the two control registers
  wire logic wr_tc = psel && penable && pwrite && paddr == 8'h00;
  wire logic wr_cc = psel && penable && pwrite && paddr == 8'h20;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  hole_error_a: assert property (pready && paddr == 8'h14 |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (pready && paddr == 8'h00 |-> !pslverr)
    else $error("mapped access refused");
  error_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  ovf_clear_a: assert property ($fell(overflow_flag) |-> $past(wr_tc))
    else $error("overflow flag fell without write");
  event_clear_a: assert property ($fell(channel_event_flag[0]) |-> $past(wr_cc))
    else $error("event flag fell without write");
  drive_start_a: assert property ($rose(ch_oe[0]) |-> $past(wr_cc || wr_tc))
    else $error("pin driven without mode write");
endmodule : timer_checker
bind timer_capture_compare_pwm timer_checker #(.NUM_CH(NUM_CH)) u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .ch_oe, .overflow_flag,
  .channel_event_flag);

// [tb/timer_capture_compare_pwm_bench.sv]
/* self-checking bench for the timer, apb master plus pin partner.
   assumes byte-wide registers on word-aligned addresses. */
module timer_capture_compare_pwm_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] TCR = 8'h00;
  localparam logic [7:0] CNH = 8'h04;
  localparam logic [7:0] CNL = 8'h08;
  localparam logic [7:0] MDH = 8'h0c;
  localparam logic [7:0] MDL = 8'h10;
  localparam logic [7:0] CC0 = 8'h20;
  localparam logic [7:0] V0H = 8'h24;
  localparam logic [7:0] V0L = 8'h28;
  localparam logic [7:0] CC1 = 8'h30;
  localparam logic [7:0] V1H = 8'h34;
  localparam logic [7:0] V1L = 8'h38;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] pin_req = 2'h0;
  logic debug_halt = 1'b0;
  logic [1:0] ch_in;
  logic ext_clk_pin;
  logic [1:0] ch_out;
  logic [1:0] ch_oe;
  logic overflow_flag;
  logic [1:0] channel_event_flag;
  logic [31:0] rd;
  logic [31:0] hi;
  logic [31:0] fl;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  // 100 ns clock
  always #50 pclk = ~pclk;
  timer_capture_compare_pwm #(.NUM_CH(2)) u_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .debug_halt,
    .fixed_tick(1'b0), .ext_clk_pin, .ch_in, .ch_out, .ch_oe, .overflow_flag,
    .channel_event_flag);
  pin_partner u_pins (.pclk, .pin_req, .ch_in, .ext_clk_pin);
  // hang guard
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails = fails + 1;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one apb transfer, held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    check(rd, {24'h0, exp});
  endtask : rdc
  // stop clock, clear overflow flag, load modulus, clear counter
  task automatic setmod(input logic [15:0] v);
    wr(TCR, 8'h00);
    xfer(1'b0, TCR, 8'h00);
    wr(TCR, 8'h00);
    wr(MDH, v[15:8]);
    wr(MDL, v[7:0]);
    wr(CNL, 8'h00);
  endtask : setmod
  // high cycles and changes of a channel pin
  task automatic watch(input int n, input int ch);
    logic last;
    hi = 0;
    fl = 0;
    last = ch_out[ch];
    repeat (n)
    begin
      @(posedge pclk);
      hi += ch_out[ch];
      fl += (ch_out[ch] != last);
      last = ch_out[ch];
    end
  endtask : watch
  task automatic test_reset();
    rdc(TCR, 8'h00);
    rdc(CC0, 8'h00);
    rdc(8'h14, 8'h00);
    rdc(CNL, 8'h00);
  endtask : test_reset
  // spacing of two overflow flags, cancelled modulus byte first
  task automatic ovf_period(input logic [7:0] ctl, input int exp);
    int t1;
    setmod(16'h0013);
    wr(MDL, 8'h09);
    wr(TCR, 8'h00);
    wr(MDH, 8'h00);
    wr(TCR, ctl);
    while (overflow_flag !== 1'b1) @(posedge pclk);
    t1 = cycles;
    xfer(1'b0, TCR, 8'h00);
    wr(TCR, ctl);
    while (overflow_flag !== 1'b1) @(posedge pclk);
    check(cycles - t1, exp);
  endtask : ovf_period
  task automatic test_capture();
    logic [15:0] held;
    setmod(16'h0013);
    wr(TCR, 8'h08);
    repeat (7) @(posedge pclk);
    wr(TCR, 8'h00);
    xfer(1'b0, CNL, 8'h00);
    held[7:0] = rd[7:0];
    xfer(1'b0, CNH, 8'h00);
    held[15:8] = rd[7:0];
    // rising, falling, then either edge
    for (int e = 1; e < 4; e++)
    begin
      xfer(1'b0, CC0, 8'h00);
      wr(CC0, 8'(e * 4));
      check(channel_event_flag[0], 0);
      pin_req <= ~pin_req;
      repeat (8) @(posedge pclk);
      check(channel_event_flag[0], 1);
      rdc(V0H, held[15:8]);
      rdc(V0L, held[7:0]);
    end
    wr(V0L, 8'h5a);
    rdc(V0L, held[7:0]);
    // debug halt: count frozen, capture still stores it
    wr(TCR, 8'h08);
    debug_halt <= 1'b1;
    xfer(1'b0, CNL, 8'h00);
    pin_req <= ~pin_req;
    repeat (8) @(posedge pclk);
    rdc(V0L, rd[7:0]);
    debug_halt <= 1'b0;
    wr(TCR, 8'h00);
    xfer(1'b0, CNH, 8'h00);
    wr(CNL, 8'h77);
    rdc(CNL, 8'h00);
  endtask : test_capture
  task automatic test_compare();
    setmod(16'h0013);
    wr(CC0, 8'h1c);
    wr(V0H, 8'h00);
    wr(V0L, 8'h05);
    wr(TCR, 8'h08);
    repeat (25) @(posedge pclk);
    check(ch_out[0], 1);
    check(channel_event_flag[0], 1);
    wr(CC0, 8'h18);
    repeat (25) @(posedge pclk);
    check(ch_out[0], 0);
    wr(CC0, 8'h14);
    wr(V0L, 8'h30);
    watch(20, 0);
    check(fl, 1);
    wr(V0H, 8'h00);
    watch(20, 0);
    check(fl, 0);
  endtask : test_compare
  task automatic pwm_case(input logic [7:0] ctl, input logic [15:0] v, input int n,
    input int exp);
    setmod(16'h0013);
    wr(CC1, 8'h28);
    wr(V1H, v[15:8]);
    wr(V1L, v[7:0]);
    wr(TCR, ctl);
    repeat (2 * n) @(posedge pclk);
    watch(n, 1);
    check(hi, exp);
  endtask : pwm_case
  task automatic test_pwm_update();
    wr(V1L, 8'h07);
    repeat (40) @(posedge pclk);
    watch(20, 1);
    check(hi, 20);
    wr(V1H, 8'h00);
    repeat (40) @(posedge pclk);
    watch(20, 1);
    check(hi, 7);
  endtask : test_pwm_update
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    ovf_period(8'h08, 20);
    ovf_period(8'h28, 38);
    ovf_period(8'h18, 80);
    test_capture();
    test_compare();
    pwm_case(8'h08, 16'h0003, 20, 3);
    pwm_case(8'h08, 16'h0000, 20, 0);
    pwm_case(8'h08, 16'h0014, 20, 20);
    test_pwm_update();
    pwm_case(8'h28, 16'h0003, 38, 6);
    pwm_case(8'h28, 16'h8003, 38, 0);
    pwm_case(8'h28, 16'h0014, 38, 38);
    print_verdict();
  end
endmodule : timer_capture_compare_pwm_bench
